// *** pkg/pwr_rst_pkg.sv ***
// shared constants and carrier types for the power and reset controller
package pwr_rst_pkg;
  localparam logic [7:0] OFS_SLEEP_CONTROL = 8'h53;
  localparam logic [7:0] OFS_GATE_CONTROL_0 = 8'h64;
  localparam logic [7:0] OFS_GATE_CONTROL_1 = 8'h65;
  localparam logic [7:0] RST_SLEEP_CONTROL = 8'h00;
  localparam logic [7:0] RST_GATE_CONTROL_0 = 8'h00;
  localparam logic [7:0] RST_GATE_CONTROL_1 = 8'h00;
  localparam int SLEEP_ARM_POS = 0;
  localparam int SLEEP_CHOICE_LSB = 1;
  localparam logic [7:0] MASK_SLEEP_CONTROL = 8'h0f;
  localparam logic [7:0] MASK_GATE_CONTROL_0 = 8'hef;
  localparam logic [7:0] MASK_GATE_CONTROL_1 = 8'h3f;
  localparam int GATE_TIMER_TWO_POS = 6;
  localparam int WAKE_STANDBY_CYCLES = 6;
  localparam int TIMEOUT_W = 20;
  // fuse-selected time-out lengths in clock cycles
  localparam logic [19:0] TIMEOUT_SHORT = 20'h0_0010;
  localparam logic [19:0] TIMEOUT_MID = 20'h0_1000;
  localparam logic [19:0] TIMEOUT_LONG = 20'h1_0000;

  typedef enum logic [2:0] {
    SLEEP_IDLE = 3'b000,
    SLEEP_NOISE_REDUCE = 3'b001,
    SLEEP_POWER_DOWN = 3'b010,
    SLEEP_POWER_SAVE = 3'b011,
    SLEEP_RSVD_4 = 3'b100,
    SLEEP_RSVD_5 = 3'b101,
    SLEEP_STANDBY = 3'b110,
    SLEEP_EXT_STANDBY = 3'b111
  } sleep_state_t;

  typedef struct packed {
    logic power_on_low;
    logic ext_pin_low;
    logic watchdog_pulse;
    logic brownout_low;
    logic test_port_reset;
  } reset_sources_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : pwr_rst_pkg

// *** hw/pin_sync3.sv ***
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module pin_sync3 import pwr_rst_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_level
);
  logic [2:0] stage;

  // only stage[1] reads stage[0]; the level changes once stages 1 and 2 agree
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stage <= 3'b000;
      o_level <= 1'b0;
    end else begin
      stage <= {stage[1:0], i_async};
      if (stage[1] == stage[2]) begin
        o_level <= stage[2];
      end
    end
  end
endmodule : pin_sync3

// *** hw/reset_stretch.sv ***
// delay counter that stretches the internal reset after all sources go quiet
`timescale 1ns/1ps
module reset_stretch import pwr_rst_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_any_src,
  input wire logic [19:0] i_timeout,
  output logic o_reset
);
  logic [19:0] count;

  // any source clears the count at once, no clock needed
  always_ff @(posedge i_clk_sys or posedge i_any_src) begin
    if (i_any_src) begin
      count <= 20'h0_0000;
      o_reset <= 1'b1;
    end else if (o_reset) begin
      if (count + 20'h0_0001 >= i_timeout) begin
        o_reset <= 1'b0;
      end
      count <= count + 20'h0_0001;
    end
  end

  a_stretch_len: assert property (@(posedge i_clk_sys)
    $fell(i_any_src) |-> o_reset [*2])
    else $error("reset released too early after sources cleared");
endmodule : reset_stretch

// *** hw/pwr_rst_ctrl.sv ***
// sleep control, peripheral clock gating and reset merging for the controller
`timescale 1ns/1ps
module pwr_rst_ctrl import pwr_rst_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sleep_instr,
  input wire logic i_wake,
  input wire logic i_timer_two_async_clock,
  input wire logic i_power_on_low,
  input wire logic i_ext_reset_n,
  input wire logic i_watchdog_pulse,
  input wire logic i_brownout_low,
  input wire logic i_brownout_enable,
  input wire logic i_test_port_reset,
  input wire logic [1:0] i_clock_choice_fuses,
  input wire logic [1:0] i_startup_time_fuses,
  input wire logic i_comparator_bandgap_select,
  input wire logic i_converter_enable,
  output logic [7:0] o_rdata,
  output logic [7:0] o_gate_control_0,
  output logic [5:0] o_gate_control_1,
  output logic o_timer_two_gated,
  output logic o_sleeping,
  output logic [2:0] o_sleep_state,
  output logic o_cpu_run,
  output logic o_port_reset,
  output logic o_internal_reset,
  output logic o_reference_enable,
  output logic o_comparator_mux_allowed
);
  logic [7:0] sleep_control;
  logic [7:0] gate_control_0;
  logic [7:0] gate_control_1;
  logic [2:0] wake_count;
  logic any_src;
  logic stretch_reset;
  logic pin_low_sync;
  logic [19:0] timeout_sel;
  logic core_rst;
  logic bo_src;
  logic wd_stretch;

  // masks off reserved bits so they never store and read zero
  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    masked = v & m;
  endfunction : masked

  // reserved codes fall back to idle so gating never goes undefined
  function automatic sleep_state_t decode_sleep(input logic [2:0] code);
    case (code)
      SLEEP_RSVD_4, SLEEP_RSVD_5: decode_sleep = SLEEP_IDLE;
      default: decode_sleep = sleep_state_t'(code);
    endcase
  endfunction : decode_sleep

  // the pin level is also synchronised; the copy is used only by the a_pin_low_held check
  pin_sync3 u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(~i_ext_reset_n),
    .o_level(pin_low_sync)
  );

  // watchdog pulse held one extra cycle so the delay starts after its fall
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wd_stretch <= 1'b0;
    end else begin
      wd_stretch <= i_watchdog_pulse;
    end
  end

  // merge of the five sources; asynchronous sources act combinationally
  assign bo_src = i_brownout_enable & i_brownout_low;
  assign any_src = i_power_on_low | ~i_ext_reset_n | i_watchdog_pulse | wd_stretch
                   | bo_src | i_test_port_reset | i_rst;

  // fuse pair picks one of three time-out lengths
  always_comb begin
    case ({i_clock_choice_fuses[0], i_startup_time_fuses[0]})
      2'b00: timeout_sel = TIMEOUT_SHORT;
      2'b01: timeout_sel = TIMEOUT_MID;
      default: timeout_sel = TIMEOUT_LONG;
    endcase
  end

  reset_stretch u_stretch (
    .i_clk_sys(i_clk_sys),
    .i_any_src(any_src),
    .i_timeout(timeout_sel),
    .o_reset(stretch_reset)
  );

  assign core_rst = stretch_reset;

  // port reset is set asynchronously by any source, released on the clock
  always_ff @(posedge i_clk_sys or posedge any_src) begin
    if (any_src) begin
      o_port_reset <= 1'b1;
    end else begin
      o_port_reset <= 1'b0;
    end
  end

  // internal reset follows the stretched reset through a flop
  always_ff @(posedge i_clk_sys or posedge any_src) begin
    if (any_src) begin
      o_internal_reset <= 1'b1;
    end else begin
      o_internal_reset <= core_rst;
    end
  end

  // sleep control register; initial value under any reset
  always_ff @(posedge i_clk_sys or posedge core_rst) begin
    if (core_rst) begin
      sleep_control <= RST_SLEEP_CONTROL;
    end else if (i_wr && i_addr == OFS_SLEEP_CONTROL) begin
      sleep_control <= masked(i_wdata, MASK_SLEEP_CONTROL);
    end
  end

  // gate registers; reserved bits dropped at write time
  always_ff @(posedge i_clk_sys or posedge core_rst) begin
    if (core_rst) begin
      gate_control_0 <= RST_GATE_CONTROL_0;
      gate_control_1 <= RST_GATE_CONTROL_1;
    end else if (i_wr) begin
      if (i_addr == OFS_GATE_CONTROL_0) begin
        gate_control_0 <= masked(i_wdata, MASK_GATE_CONTROL_0);
      end
      if (i_addr == OFS_GATE_CONTROL_1) begin
        gate_control_1 <= masked(i_wdata, MASK_GATE_CONTROL_1);
      end
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys or posedge core_rst) begin
    if (core_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        OFS_SLEEP_CONTROL: o_rdata <= sleep_control;
        OFS_GATE_CONTROL_0: o_rdata <= gate_control_0;
        OFS_GATE_CONTROL_1: o_rdata <= gate_control_1;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // clock gate enables; a gated block simply stops, keeping its state
  always_ff @(posedge i_clk_sys or posedge core_rst) begin
    if (core_rst) begin
      o_gate_control_0 <= 8'h00;
      o_gate_control_1 <= 6'h00;
      o_timer_two_gated <= 1'b0;
      o_comparator_mux_allowed <= 1'b1;
    end else begin
      o_gate_control_0 <= gate_control_0;
      o_gate_control_1 <= gate_control_1[5:0];
      // async timer two keeps its own clock, so the gate bit has no effect
      o_timer_two_gated <= gate_control_0[GATE_TIMER_TWO_POS]
                           & ~i_timer_two_async_clock;
      o_comparator_mux_allowed <= ~gate_control_0[0];
    end
  end

  // sleep entry only when armed; wake from standby modes waits six cycles
  always_ff @(posedge i_clk_sys or posedge core_rst) begin
    if (core_rst) begin
      o_sleeping <= 1'b0;
      o_sleep_state <= SLEEP_IDLE;
      wake_count <= 3'h0;
      o_cpu_run <= 1'b0;
    end else begin
      o_cpu_run <= 1'b1;
      if (o_sleeping && i_wake) begin
        o_sleeping <= 1'b0;
        if (o_sleep_state == SLEEP_STANDBY || o_sleep_state == SLEEP_EXT_STANDBY) begin
          wake_count <= 3'(WAKE_STANDBY_CYCLES);
          o_cpu_run <= 1'b0;
        end
      end else if (wake_count != 3'h0) begin
        wake_count <= wake_count - 3'h1;
        o_cpu_run <= (wake_count == 3'h1);
      end else if (!o_sleeping && i_sleep_instr && sleep_control[SLEEP_ARM_POS]) begin
        o_sleeping <= 1'b1;
        o_cpu_run <= 1'b0;
        o_sleep_state <= decode_sleep(sleep_control[SLEEP_CHOICE_LSB +: 3]);
      end
      if (o_sleeping) begin
        o_cpu_run <= 1'b0;
      end
    end
  end

  // reference on only while one of its users needs it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reference_enable <= 1'b0;
    end else begin
      o_reference_enable <= i_brownout_enable | i_comparator_bandgap_select
                            | i_converter_enable;
    end
  end

  a_sleep_needs_arm: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    $rose(o_sleeping) |-> $past(sleep_control[0]))
    else $error("sleep entered without arm bit");
  a_rsvd_reads_zero: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    gate_control_0[4] == 1'b0 && gate_control_1[7:6] == 2'b00)
    else $error("reserved gate bit stored");
  a_timer_two_async: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    i_timer_two_async_clock ##1 i_timer_two_async_clock |-> !o_timer_two_gated)
    else $error("async timer two gated");
  a_no_rsvd_state: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    o_sleeping |-> o_sleep_state != 3'b100 && o_sleep_state != 3'b101)
    else $error("reserved sleep state applied");
  a_standby_wake_six: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    (o_sleeping && i_wake && o_sleep_state == SLEEP_STANDBY)
      |=> !o_cpu_run [*6] ##1 o_cpu_run)
    else $error("standby wake not six cycles");
  a_port_rst_async: assert property (@(posedge i_clk_sys)
    any_src |-> o_port_reset)
    else $error("port reset missing with active source");
  a_ref_users: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $past(i_converter_enable) |-> o_reference_enable)
    else $error("reference off while converter enabled");
  // the synchronised pin copy lags the raw pin, so it can only fall inside the stretch
  a_pin_low_held: assert property (@(posedge i_clk_sys)
    pin_low_sync |-> o_internal_reset)
    else $error("reset pin low but internal reset released");
  a_test_port_hold: assert property (@(posedge i_clk_sys)
    i_test_port_reset |-> o_internal_reset)
    else $error("test port reset not held");
  a_mux_blocked: assert property (@(posedge i_clk_sys) disable iff (core_rst)
    $past(gate_control_0[0]) |-> !o_comparator_mux_allowed)
    else $error("comparator mux allowed while gated");
  c_sleep_entry: cover property (@(posedge i_clk_sys) $rose(o_sleeping));
  c_standby_wake: cover property (@(posedge i_clk_sys)
    o_sleeping && i_wake && o_sleep_state == SLEEP_EXT_STANDBY);
  c_reset_release: cover property (@(posedge i_clk_sys) $fell(o_internal_reset));
  c_timer_gate: cover property (@(posedge i_clk_sys) $rose(o_timer_two_gated));
endmodule : pwr_rst_ctrl

// *** tb/test_sleep_clock_gate_reset_ctrl.sv ***
// self-checking bench for the sleep, clock gating and reset controller
`timescale 1ns/1ps
module test_sleep_clock_gate_reset_ctrl import pwr_rst_pkg::*;;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0, i_rd = 1'b0, i_sleep_instr = 1'b0, i_wake = 1'b0;
  logic i_timer_two_async_clock = 1'b0, i_power_on_low = 1'b0, i_ext_reset_n = 1'b1;
  logic i_watchdog_pulse = 1'b0, i_brownout_low = 1'b0, i_brownout_enable = 1'b0;
  logic i_test_port_reset = 1'b0, i_comparator_bandgap_select = 1'b0;
  logic i_converter_enable = 1'b0;
  logic [7:0] o_rdata, o_gate_control_0;
  logic [5:0] o_gate_control_1;
  logic [2:0] o_sleep_state;
  logic o_timer_two_gated, o_sleeping, o_cpu_run, o_port_reset, o_internal_reset;
  logic o_reference_enable, o_comparator_mux_allowed;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  pwr_rst_ctrl u_pwr_rst_ctrl (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_sleep_instr(i_sleep_instr),
    .i_wake(i_wake), .i_timer_two_async_clock(i_timer_two_async_clock),
    .i_power_on_low(i_power_on_low), .i_ext_reset_n(i_ext_reset_n),
    .i_watchdog_pulse(i_watchdog_pulse), .i_brownout_low(i_brownout_low),
    .i_brownout_enable(i_brownout_enable), .i_test_port_reset(i_test_port_reset),
    .i_clock_choice_fuses(2'h0), .i_startup_time_fuses(2'h0),
    .i_comparator_bandgap_select(i_comparator_bandgap_select),
    .i_converter_enable(i_converter_enable), .o_rdata(o_rdata),
    .o_gate_control_0(o_gate_control_0), .o_gate_control_1(o_gate_control_1),
    .o_timer_two_gated(o_timer_two_gated), .o_sleeping(o_sleeping),
    .o_sleep_state(o_sleep_state), .o_cpu_run(o_cpu_run), .o_port_reset(o_port_reset),
    .o_internal_reset(o_internal_reset), .o_reference_enable(o_reference_enable),
    .o_comparator_mux_allowed(o_comparator_mux_allowed));

  // 50 MHz system clock
  always #10 i_clk_sys = ~i_clk_sys;

  task automatic close_out;
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // hang guard: the whole sequence needs a few hundred cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick

  // one-cycle write strobe; outputs are looked at once the next edge has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  // counts edges until the stretched reset lets go, bounded
  task automatic wait_rel(output int n);
    n = 0;
    while (o_internal_reset !== 1'b0 && n < 100) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
  endtask : wait_rel

  task automatic set_src(input int s, input logic v);
    case (s)
      0: i_power_on_low <= v;
      1: i_ext_reset_n <= ~v;
      2: i_watchdog_pulse <= v;
      3: i_brownout_low <= v;
      default: i_test_port_reset <= v;
    endcase
  endtask : set_src

  function automatic logic [2:0] exp_state(input logic [2:0] c);
    return (c == 3'h4 || c == 3'h5) ? 3'h0 : c;
  endfunction : exp_state

  initial begin
    logic [7:0] d, v;
    logic [2:0] code;
    logic arm;
    int n;
    void'($urandom(32'h1c6a));
    tick(2);
    @(posedge i_clk_sys) i_rst <= 1'b0;
    wait_rel(n);
    rd(OFS_SLEEP_CONTROL, d); chk_byte(d, RST_SLEEP_CONTROL, "sleep reset");
    rd(OFS_GATE_CONTROL_0, d); chk_byte(d, RST_GATE_CONTROL_0, "gate0 reset");
    rd(OFS_GATE_CONTROL_1, d); chk_byte(d, RST_GATE_CONTROL_1, "gate1 reset");
    // random register traffic, corner values first
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 8'hff : (k == 1) ? 8'h10 : 8'($urandom);
      @(posedge i_clk_sys) i_timer_two_async_clock <= 1'($urandom);
      // software would reinitialise any ungated serial block after this write
      wr(OFS_GATE_CONTROL_0, v);
      tick(1);
      chk_byte(o_gate_control_0, v & 8'hef, "gate0 out");
      chk_bit(o_timer_two_gated, v[6] & ~i_timer_two_async_clock, "t2 gate");
      chk_bit(o_comparator_mux_allowed, ~v[0], "mux");
      rd(OFS_GATE_CONTROL_0, d); chk_byte(d, v & 8'hef, "gate0 read");
      wr(OFS_GATE_CONTROL_1, v);
      tick(1);
      chk_byte({2'h0, o_gate_control_1}, v & 8'h3f, "gate1 out");
      rd(OFS_GATE_CONTROL_1, d); chk_byte(d, v & 8'h3f, "gate1 read");
      wr(OFS_SLEEP_CONTROL, v & 8'hfe);
      rd(OFS_SLEEP_CONTROL, d); chk_byte(d, v & 8'h0e, "sleep read");
      rd(8'h70, d); chk_byte(d, 8'h00, "unmapped read");
    end
    // every sleep code armed, then one unarmed instruction
    for (int c = 0; c < 9; c++) begin
      code = 3'(c);
      arm = (c < 8);
      wr(OFS_SLEEP_CONTROL, {4'h0, code, arm});
      @(posedge i_clk_sys) i_sleep_instr <= 1'b1;
      @(posedge i_clk_sys) i_sleep_instr <= 1'b0;
      tick(1);
      chk_bit(o_sleeping, arm, "sleeping");
      if (arm) begin
        chk_byte({5'h0, o_sleep_state}, {5'h0, exp_state(code)}, "state");
        chk_bit(o_cpu_run, 1'b0, "run in sleep");
        @(posedge i_clk_sys) i_wake <= 1'b1;
        @(posedge i_clk_sys) i_wake <= 1'b0;
        #1;
        n = 1;
        while (o_cpu_run !== 1'b1 && n < 20) begin
          @(posedge i_clk_sys);
          #1;
          n++;
        end
        chk_bit((code[2:1] == 2'b11) ? (n >= 6 && n <= 9) : (n <= 3), 1'b1, "wake");
      end
      wr(OFS_SLEEP_CONTROL, 8'h00); // software disarms after waking
    end
    // reference enable over all user combinations
    for (int m = 0; m < 8; m++) begin
      @(posedge i_clk_sys);
      {i_brownout_enable, i_comparator_bandgap_select, i_converter_enable} <= 3'(m);
      tick(2); // users wait for the reference to settle before use
      chk_bit(o_reference_enable, (m != 0), "reference");
    end
    // disabled brownout detector must not reset
    @(posedge i_clk_sys) {i_brownout_enable, i_brownout_low} <= 2'b01;
    tick(3);
    chk_bit(o_internal_reset, 1'b0, "bod off");
    @(posedge i_clk_sys) {i_brownout_enable, i_brownout_low} <= 2'b10;
    // each reset source: async assertion, hold (all but the watchdog), stretched release, gate register 0 cleared
    for (int s = 0; s < 5; s++) begin
      wr(OFS_GATE_CONTROL_0, 8'hff);
      @(posedge i_clk_sys) set_src(s, 1'b1);
      #1;
      chk_bit(o_port_reset, 1'b1, "port reset");
      if (s != 2) begin
        tick(3);
        chk_bit(o_internal_reset, 1'b1, "held");
      end
      // watchdog pulse stands exactly one clock cycle
      @(posedge i_clk_sys) set_src(s, 1'b0);
      if (s == 0) begin
        tick(5);
        @(posedge i_clk_sys) set_src(0, 1'b1);
        #1;
        chk_bit(o_port_reset, 1'b1, "por again");
        @(posedge i_clk_sys) set_src(0, 1'b0);
      end
      wait_rel(n);
      chk_bit(n >= 16 && n <= 24, 1'b1, "stretch");
      rd(OFS_GATE_CONTROL_0, d); chk_byte(d, 8'h00, "cleared");
    end
    close_out();
  end
endmodule : test_sleep_clock_gate_reset_ctrl
